// ===== rtl/dac_pkg.sv
package dac_pkg;
  // ----------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------
  localparam int unsigned CFG_W          = 16;
  localparam int unsigned BIT_CLK_MODE   = 11;
  localparam int unsigned BIT_DATA_LINES = 10;
  localparam int unsigned BIT_RANGE      = 9;
  localparam int unsigned BIT_INPUT      = 7;
  localparam int unsigned BIT_REF        = 6;
  localparam int unsigned BIT_STANDBY    = 5;
  localparam int unsigned BIT_FORMAT     = 4;
  localparam logic [15:0] CFG_RESET      = 16'h0000;
  localparam logic [15:0] CFG_KEEP_MASK  = 16'h0ef0;
  // ----------------------------------------------------------------
  // Reference DAC registers
  // ----------------------------------------------------------------
  localparam int unsigned REFDAC_W       = 9;
  localparam logic [8:0]  REFDAC_RESET   = 9'h1ff;
  // ----------------------------------------------------------------
  // Command codes in bits 15:12
  // ----------------------------------------------------------------
  localparam logic [3:0]  CMD_RD_DAC_A   = 4'h1;
  localparam logic [3:0]  CMD_RD_DAC_B   = 4'h2;
  localparam logic [3:0]  CMD_RD_CFG     = 4'h3;
  localparam logic [3:0]  CMD_WR_CFG     = 4'h8;
  localparam logic [3:0]  CMD_WR_DAC_A   = 4'h9;
  localparam logic [3:0]  CMD_WR_DAC_B   = 4'ha;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 50;
  localparam int unsigned CONV_NS        = 400;
  localparam int unsigned CONV_CYC       = (CONV_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } dac_state_t;
endpackage

// ===== rtl/dac_core.sv
`timescale 1ns/1ps
// Function
// - With reference select low the internal reference is off and both channels use external references.
// - The reference select is one bit shared by both channels.
// - With reference select high each channel reference follows its own reference DAC register.
// - The shared range bit sets full scale to one reference when low and twice it when high.
// - The shared input bit selects single-ended when low and pseudo-differential when high.
// - The format bit selects straight binary when low and twos complement when high.
// - Result width is 16, 14 or 12 bits and one LSB is full scale over two to that width.
// - Straight binary gives zero at bottom, half at midscale and all ones at full scale.
// - Twos complement gives the most negative code at bottom, zero at midscale, most positive at top.
// - Both channels sample at the same instant and convert their own input differences together.
// - Configuration and both reference DAC registers can be written and read back.
// - Four readout modes and one standby mode are supported.
// - A configuration written in a valid frame takes effect from the next frame.
// - At power-up the configuration register clears to zero.
module dac_core #(
  parameter int unsigned RES_W = 16
) (
  // Clock and reset
  input  wire logic                          MCLK_I,
  input  wire logic                          RST_I,
  // Frame and register access
  input  wire logic                          FRAME_START_I,
  input  wire logic                          FRAME_VALID_END_I,
  input  wire logic                          FRAME_ABORT_I,
  input  wire logic [15:0]                   CMD_WORD_I,
  // Analog front end samples, unsigned offset from the negative input
  input  wire logic [RES_W-1:0]              RAW_A_I,
  input  wire logic [RES_W-1:0]              RAW_B_I,
  input  wire logic                          RAW_UNDER_A_I,
  input  wire logic                          RAW_OVER_A_I,
  input  wire logic                          RAW_UNDER_B_I,
  input  wire logic                          RAW_OVER_B_I,
  // Analog control outputs
  output logic                               SAMPLE_O,
  output logic                               INT_REF_EN_O,
  output logic [dac_pkg::REFDAC_W-1:0]       REF_LEVEL_A_O,
  output logic [dac_pkg::REFDAC_W-1:0]       REF_LEVEL_B_O,
  output logic                               RANGE_DOUBLE_O,
  output logic                               PSEUDO_DIFF_O,
  output logic                               CLK_MODE_16_O,
  output logic                               SINGLE_LINE_O,
  output logic                               STANDBY_O,
  // Results and readback
  output logic [RES_W-1:0]                   RESULT_A_O,
  output logic [RES_W-1:0]                   RESULT_B_O,
  output logic                               RESULT_VALID_O,
  output logic [15:0]                        READBACK_O,
  output logic                               READBACK_VALID_O
);
  import dac_pkg::*;

  // ----------------------------------------------------------------
  // Registers written by the host
  // ----------------------------------------------------------------
  logic [15:0]         cfg_q;
  logic [15:0]         act_q;
  logic [REFDAC_W-1:0] dac_a_q;
  logic [REFDAC_W-1:0] dac_b_q;
  logic [3:0]          cmd;
  logic                wr_cfg;
  logic                wr_dac_a;
  logic                wr_dac_b;
  logic                rd_any;
  logic [15:0]         rd_word;

  assign cmd      = CMD_WORD_I[15:12];
  assign wr_cfg   = FRAME_VALID_END_I && (cmd == CMD_WR_CFG);
  assign wr_dac_a = FRAME_VALID_END_I && (cmd == CMD_WR_DAC_A);
  assign wr_dac_b = FRAME_VALID_END_I && (cmd == CMD_WR_DAC_B);
  assign rd_any   = FRAME_VALID_END_I &&
                    (cmd == CMD_RD_CFG || cmd == CMD_RD_DAC_A || cmd == CMD_RD_DAC_B);
  // Readback mirrors the stored layout, reserved bits zero
  assign rd_word  = (cmd == CMD_RD_CFG)   ? cfg_q :
                    (cmd == CMD_RD_DAC_A) ? {4'h0, dac_a_q, 3'h0} :
                    (cmd == CMD_RD_DAC_B) ? {4'h0, dac_b_q, 3'h0} : 16'h0000;

  // Aborted frames write nothing
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      cfg_q   <= CFG_RESET;
      dac_a_q <= REFDAC_RESET;
      dac_b_q <= REFDAC_RESET;
    end else begin
      if (wr_cfg) begin
        cfg_q <= CMD_WORD_I & CFG_KEEP_MASK;
      end
      if (wr_dac_a) begin
        dac_a_q <= CMD_WORD_I[11:3];
      end
      if (wr_dac_b) begin
        dac_b_q <= CMD_WORD_I[11:3];
      end
    end
  end

  // Active copy is taken at the next frame start, so a frame never
  // sees its own write
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      act_q <= CFG_RESET;
    end else if (FRAME_START_I) begin
      act_q <= cfg_q;
    end
  end

  // ----------------------------------------------------------------
  // Configuration outputs, per-channel reference levels and readback
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      INT_REF_EN_O     <= 1'b0;
      REF_LEVEL_A_O    <= REFDAC_RESET;
      REF_LEVEL_B_O    <= REFDAC_RESET;
      RANGE_DOUBLE_O   <= 1'b0;
      PSEUDO_DIFF_O    <= 1'b0;
      CLK_MODE_16_O    <= 1'b0;
      SINGLE_LINE_O    <= 1'b0;
      STANDBY_O        <= 1'b0;
      READBACK_O       <= 16'h0000;
      READBACK_VALID_O <= 1'b0;
    end else begin
      INT_REF_EN_O     <= act_q[BIT_REF];
      REF_LEVEL_A_O    <= dac_a_q;
      REF_LEVEL_B_O    <= dac_b_q;
      RANGE_DOUBLE_O   <= act_q[BIT_RANGE];
      PSEUDO_DIFF_O    <= act_q[BIT_INPUT];
      CLK_MODE_16_O    <= act_q[BIT_CLK_MODE];
      SINGLE_LINE_O    <= act_q[BIT_DATA_LINES];
      STANDBY_O        <= act_q[BIT_STANDBY];
      READBACK_VALID_O <= rd_any;
      if (rd_any) begin
        READBACK_O <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  localparam int unsigned CW = $clog2(CONV_CYC + 1);
  dac_state_t    st_q;
  dac_state_t    st_d;
  logic [CW-1:0] cnt_q;
  logic          conv_end;

  assign conv_end = (cnt_q == CW'(CONV_CYC - 1));

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      // Judge on the word being applied now, not the outgoing copy
      ST_IDLE: if (FRAME_START_I && !cfg_q[BIT_STANDBY]) st_d = ST_CONV;
      ST_CONV: begin
        if (FRAME_ABORT_I) begin
          st_d = ST_IDLE;
        end else if (conv_end) begin
          st_d = ST_DONE;
        end
      end
      ST_DONE: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q  <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= (st_q == ST_CONV) ? cnt_q + CW'(1) : '0;
    end
  end

  // ----------------------------------------------------------------
  // Output coding, common to both channels
  // ----------------------------------------------------------------
  function automatic logic [RES_W-1:0] code(input logic [RES_W-1:0] raw,
                                            input logic under,
                                            input logic over,
                                            input logic twos);
    logic [RES_W-1:0] sb;
    sb = under ? '0 : (over ? '1 : raw);
    code = twos ? {~sb[RES_W-1], sb[RES_W-2:0]} : sb;
  endfunction

  logic [RES_W-1:0] code_a;
  logic [RES_W-1:0] code_b;
  assign code_a = code(RAW_A_I, RAW_UNDER_A_I, RAW_OVER_A_I, act_q[BIT_FORMAT]);
  assign code_b = code(RAW_B_I, RAW_UNDER_B_I, RAW_OVER_B_I, act_q[BIT_FORMAT]);

  // One strobe samples both channels, so they share an instant
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      SAMPLE_O       <= 1'b0;
      RESULT_A_O     <= '0;
      RESULT_B_O     <= '0;
      RESULT_VALID_O <= 1'b0;
    end else begin
      SAMPLE_O       <= (st_d == ST_CONV) && (st_q == ST_IDLE);
      RESULT_VALID_O <= (st_q == ST_DONE);
      if (st_q == ST_DONE) begin
        RESULT_A_O <= code_a;
        RESULT_B_O <= code_b;
      end
    end
  end
endmodule

// ===== verif/dac_core_asserts.sv
`timescale 1ns/1ps
module dac_core_asserts
  import dac_pkg::*;
(
  input wire logic        MCLK_I,
  input wire logic        RST_I,
  input wire logic        FRAME_START_I,
  input wire logic        FRAME_VALID_END_I,
  input wire logic        FRAME_ABORT_I,
  input wire logic [15:0] CMD_WORD_I,
  input wire logic        SAMPLE_O,
  input wire logic        INT_REF_EN_O,
  input wire logic [8:0]  REF_LEVEL_A_O,
  input wire logic [8:0]  REF_LEVEL_B_O,
  input wire logic        RANGE_DOUBLE_O,
  input wire logic        PSEUDO_DIFF_O,
  input wire logic        CLK_MODE_16_O,
  input wire logic        SINGLE_LINE_O,
  input wire logic        STANDBY_O,
  input wire logic        RESULT_VALID_O,
  input wire logic [15:0] READBACK_O,
  input wire logic        READBACK_VALID_O
);
  wire       wr_a = FRAME_VALID_END_I && (CMD_WORD_I[15:12] == CMD_WR_DAC_A);
  wire       wr_b = FRAME_VALID_END_I && (CMD_WORD_I[15:12] == CMD_WR_DAC_B);
  wire       rd_a = FRAME_VALID_END_I && (CMD_WORD_I[15:12] == CMD_RD_DAC_A);
  wire [8:0] dval = CMD_WORD_I[11:3];
  wire [5:0] cfgs = {INT_REF_EN_O, RANGE_DOUBLE_O, PSEUDO_DIFF_O,
                     CLK_MODE_16_O, SINGLE_LINE_O, STANDBY_O};
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  chk_sample_cause: assert property (SAMPLE_O |-> $past(FRAME_START_I))
    else $error("sample without frame start");
  chk_sample_gap: assert property (SAMPLE_O |=> !SAMPLE_O [*8])
    else $error("second sample during conversion");
  chk_result_delay: assert property (RESULT_VALID_O |-> $past(SAMPLE_O, 21))
    else $error("result not 21 cycles after sample");
  // Register takes the word at the write edge, the level pin one edge later
  chk_dac_a_write: assert property (wr_a |=> ##1 REF_LEVEL_A_O == $past(dval, 2))
    else $error("channel A level not written");
  chk_dac_b_write: assert property (
    wr_b |=> ##1 REF_LEVEL_B_O == $past(dval, 2) && $stable(REF_LEVEL_A_O))
    else $error("channel B write wrong");
  chk_abort_keep: assert property (FRAME_ABORT_I |=> $stable(REF_LEVEL_A_O) && $stable(REF_LEVEL_B_O))
    else $error("aborted frame changed a level");
  chk_cfg_timing: assert property ($changed(cfgs) |-> $past(FRAME_START_I, 2))
    else $error("config output changed off frame start");
  chk_dac_readback: assert property (
    rd_a |=> READBACK_VALID_O && READBACK_O == {4'h0, REF_LEVEL_A_O, 3'h0})
    else $error("channel A readback wrong");
endmodule
bind dac_core dac_core_asserts u_chk (.*);

// ===== verif/dac_host.sv
`timescale 1ns/1ps
module dac_host (
  // Frame control toward the converter
  input  wire logic   clk_i,
  output logic        start_o,
  output logic        end_o,
  output logic        abort_o,
  output logic [15:0] cmd_o
);
  initial begin
    start_o = 1'b0;
    end_o = 1'b0;
    abort_o = 1'b0;
    cmd_o = 16'h0000;
  end
  // Word is only meaningful at the frame end; scrambled otherwise
  task automatic frame(input logic [15:0] cmd, input logic abrt);
    @(negedge clk_i);
    start_o = 1'b1;
    @(negedge clk_i);
    start_o = 1'b0;
    repeat (2) @(negedge clk_i);
    cmd_o = cmd;
    if (abrt) abort_o = 1'b1;
    else end_o = 1'b1;
    @(negedge clk_i);
    abort_o = 1'b0;
    end_o = 1'b0;
    cmd_o = ~cmd;
  endtask
endmodule

// ===== verif/tb_dual_adc_config_and_output_coding.sv
`timescale 1ns/1ps
module tb_dual_adc_config_and_output_coding;
  import dac_pkg::*;
  typedef struct {logic [15:0] cfg, raw, ex; logic un, ov;} dac_row_t;
  logic MCLK_I, RST_I, RAW_UNDER_A_I, RAW_OVER_A_I, RAW_UNDER_B_I, RAW_OVER_B_I;
  logic [15:0] RAW_A_I, RAW_B_I;
  wire FRAME_START_I, FRAME_VALID_END_I, FRAME_ABORT_I, SAMPLE_O, INT_REF_EN_O, RANGE_DOUBLE_O;
  wire PSEUDO_DIFF_O, CLK_MODE_16_O, SINGLE_LINE_O, STANDBY_O, RESULT_VALID_O, READBACK_VALID_O;
  wire [15:0] CMD_WORD_I, RESULT_A_O, RESULT_B_O, READBACK_O;
  wire [8:0]  REF_LEVEL_A_O, REF_LEVEL_B_O;
  // Active configuration outputs placed at their bit positions, format bit left out
  wire [15:0] cfg_seen = {4'h0, CLK_MODE_16_O, SINGLE_LINE_O, RANGE_DOUBLE_O, 1'b0,
                          PSEUDO_DIFF_O, INT_REF_EN_O, STANDBY_O, 5'h00};
  int err_total = 0, tests_run = 0, cyc = 0;
  dac_row_t rows[6] = '{'{16'h0000, 16'h7fff, 16'h7fff, 0, 0}, '{16'h0000, 16'h1234, 16'h0000, 1, 0},
    '{16'h0280, 16'h0000, 16'hffff, 0, 1}, '{16'h0010, 16'h8000, 16'h0000, 0, 0},
    '{16'h0050, 16'h1234, 16'h8000, 1, 0}, '{16'h02d0, 16'h0000, 16'h7fff, 0, 1}};
  dac_core uut (.*);
  dac_host u_host (.clk_i(MCLK_I), .start_o(FRAME_START_I), .end_o(FRAME_VALID_END_I),
                   .abort_o(FRAME_ABORT_I), .cmd_o(CMD_WORD_I));
  initial begin
    MCLK_I = 1'b0;
    forever #10 MCLK_I = ~MCLK_I;
  end
  // ------------------------------------------------------------
  // Compare and closing
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    tests_run++;
    if (got !== ex) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic conclude();
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wres(input logic want = 1'b1);
    int n;
    n = 0;
    do begin
      @(posedge MCLK_I);
      #1 n++;
    end while (RESULT_VALID_O !== 1'b1 && n < 40);
    chk("result_valid", {15'h0, want}, {15'h0, RESULT_VALID_O});
  endtask
  always @(posedge MCLK_I) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      conclude();
    end
  end
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    RST_I = 1'b1;
    {RAW_UNDER_A_I, RAW_OVER_A_I, RAW_UNDER_B_I, RAW_OVER_B_I} = 4'h0;
    RAW_A_I = 16'h0000;
    RAW_B_I = 16'h0000;
    repeat (4) @(posedge MCLK_I);
    @(negedge MCLK_I) RST_I = 1'b0;
    chk("ref_a_rst", 16'h01ff, {7'h0, REF_LEVEL_A_O});
    foreach (rows[i]) begin
      u_host.frame({4'h8, rows[i].cfg[11:0]}, 1'b0);
      wres();
      @(negedge MCLK_I);
      RAW_A_I = rows[i].raw;
      RAW_B_I = rows[i].raw;
      {RAW_UNDER_A_I, RAW_UNDER_B_I} = {2{rows[i].un}};
      {RAW_OVER_A_I, RAW_OVER_B_I} = {2{rows[i].ov}};
      u_host.frame(16'h0000, 1'b0);
      wres();
      chk("result_a", rows[i].ex, RESULT_A_O);
      chk("result_b", rows[i].ex, RESULT_B_O);
      chk("cfg_out", {13'h0, rows[i].cfg[6], rows[i].cfg[9], rows[i].cfg[7]},
          {13'h0, INT_REF_EN_O, RANGE_DOUBLE_O, PSEUDO_DIFF_O});
    end
    u_host.frame(16'h8000, 1'b0);
    wres();
    chk("cfg_same_frame", 16'h0001, {15'h0, INT_REF_EN_O});
    u_host.frame(16'h9c38, 1'b0);
    wres();
    chk("cfg_next_frame", 16'h0000, {15'h0, INT_REF_EN_O});
    u_host.frame(16'ha008, 1'b1);
    wres(1'b0);
    chk("ref_b_abort", 16'h01ff, {7'h0, REF_LEVEL_B_O});
    u_host.frame(16'ha010, 1'b0);
    wres();
    chk("ref_b", 16'h0002, {7'h0, REF_LEVEL_B_O});
    chk("ref_a", 16'h0187, {7'h0, REF_LEVEL_A_O});
    u_host.frame(16'h1000, 1'b0);
    wres();
    chk("readback_a", 16'h0c38, READBACK_O);
    u_host.frame(16'h8e90, 1'b0);
    wres();
    u_host.frame(16'h3000, 1'b0);
    wres();
    chk("readback_cfg", 16'h0e90, READBACK_O);
    chk("cfg_modes", 16'h0e80, cfg_seen);
    u_host.frame(16'h8020, 1'b0);
    wres();
    // Standby applied at this frame start, so no conversion follows
    u_host.frame(16'h0000, 1'b0);
    wres(1'b0);
    chk("standby", 16'h0020, cfg_seen);
    // Second reset in mid-run
    @(negedge MCLK_I) RST_I = 1'b1;
    repeat (4) @(negedge MCLK_I);
    RST_I = 1'b0;
    chk("cfg_rst", 16'h0000, {13'h0, INT_REF_EN_O, RANGE_DOUBLE_O, PSEUDO_DIFF_O});
    chk("ref_b_rst", 16'h01ff, {7'h0, REF_LEVEL_B_O});
    // Inputs still over range; cleared format must give straight binary again
    u_host.frame(16'h0000, 1'b0);
    wres();
    chk("result_rst", 16'hffff, RESULT_A_O);
    conclude();
  end
endmodule
